// file: hdl/can_pack_pkg.sv
// shared constants, types and reset state for the can signal packer
package can_pack_pkg;
	localparam int N_SLOT = 4;
	localparam int N_SRC = 4;
	localparam int CLK_NS = 100;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS;
	localparam int FRAC = 16;
	localparam int CNT_W = 14;
	localparam logic [3:0] MAX_LEN = 4'h8;
	localparam logic [3:0] MAX_POS = 4'h8;
	localparam logic [5:0] MAX_SIZE = 6'h20;
	localparam logic [7:0] MAX_SEL = 8'hfd;
	// own source address placed in sent frames; arbitrary value
	localparam logic [7:0] OWN_ADDR = 8'h80;
	// byte addresses
	localparam logic [7:0] A_TX_CTRL = 8'h00;
	localparam logic [7:0] A_TX_RATE = 8'h04;
	localparam logic [7:0] A_TX_PGN = 8'h08;
	localparam logic [7:0] A_SLOT0 = 8'h10;
	localparam logic [7:0] SLOT_STRIDE = 8'h10;
	localparam logic [7:0] S_CFG = 8'h00;
	localparam logic [7:0] S_RES = 8'h04;
	localparam logic [7:0] S_OFF = 8'h08;
	localparam logic [7:0] A_RX_CFG = 8'h50;
	localparam logic [7:0] A_RX_PGN = 8'h54;
	localparam logic [7:0] A_RX_RES = 8'h58;
	localparam logic [7:0] A_RX_OFF = 8'h5c;
	localparam logic [7:0] A_RX_ARST = 8'h60;
	localparam logic [7:0] A_RX_VAL = 8'h64;
	localparam logic [7:0] A_STATUS = 8'h68;
	// field positions
	localparam int F_TYPE = 0;
	localparam int F_FILT = 2;
	localparam int F_SRC = 4;
	localparam int F_BYTE = 8;
	localparam int F_BIT = 12;
	localparam int F_SIZE = 16;
	localparam int F_SEL = 24;
	localparam int F_EN = 0;
	localparam int F_REQ = 1;
	localparam int F_LEN = 8;
	// signal kinds
	localparam logic [1:0] T_UNDEF = 2'h0;
	localparam logic [1:0] T_DISC = 2'h1;
	localparam logic [1:0] T_CONT = 2'h2;

	typedef struct packed {
		logic [1:0] kind;
		logic [2:0] src;
		logic [3:0] byte_pos;
		logic [3:0] bit_pos;
		logic [5:0] size;
	} slot_cfg_t;

	typedef struct packed {
		logic [17:0] pgn;
		logic [7:0] src;
		logic [3:0] len;
		logic [63:0] data;
	} can_frame_t;

	typedef struct packed {
		logic hready_o;
		logic hresp;
		logic [31:0] hrdata;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic tx_en;
		logic tx_req;
		logic [3:0] tx_len;
		logic [CNT_W-1:0] tx_rate;
		logic [17:0] tx_pgn;
		slot_cfg_t [N_SLOT-1:0] slot;
		logic [N_SLOT-1:0][31:0] slot_res;
		logic [N_SLOT-1:0][31:0] slot_off;
		slot_cfg_t rx_cfg;
		logic rx_filt;
		logic [7:0] rx_sel;
		logic [17:0] rx_pgn;
		logic [31:0] rx_res;
		logic [31:0] rx_off;
		logic [CNT_W-1:0] rx_arst;
		logic [CNT_W-1:0] ms_cnt;
		logic [CNT_W-1:0] tx_ms;
		logic [CNT_W-1:0] rx_ms;
		logic tx_valid;
		can_frame_t tx_frame;
		logic rx_strobe;
		logic rx_live;
		logic [31:0] rx_value;
	} state_t;

	localparam slot_cfg_t SLOT_R0 = '{T_CONT, 3'h1, 4'h1, 4'h1, 6'h10};
	localparam slot_cfg_t SLOT_R1 = '{T_CONT, 3'h2, 4'h3, 4'h1, 6'h10};
	localparam slot_cfg_t SLOT_RU = '{T_UNDEF, 3'h0, 4'h1, 4'h1, 6'h01};
	localparam slot_cfg_t RX_CFG_R = '{T_UNDEF, 3'h0, 4'h1, 4'h1, 6'h01};
	// 16.16 units: 0x01f40000 is 1/0.002, 0x00010000 is 1.0
	localparam logic [31:0] RES_R = 32'h01f40000;
	localparam logic [31:0] ONE_R = 32'h00010000;
	localparam logic [31:0] OFF_R = 32'hffffffc0;
	localparam state_t ST_RST = '{
		hready_o: 1'b1,
		tx_len: 4'h8,
		tx_rate: 14'h000a,
		tx_pgn: 18'h0f013,
		slot: '{SLOT_RU, SLOT_RU, SLOT_R1, SLOT_R0},
		slot_res: '{ONE_R, ONE_R, RES_R, RES_R},
		slot_off: '{32'h0, 32'h0, OFF_R, OFF_R},
		rx_cfg: RX_CFG_R,
		rx_pgn: 18'h0ffff,
		rx_res: ONE_R,
		rx_arst: 14'h01f4,
		default: '0
	};
endpackage

// file: hdl/can_signal_pack_unpack.sv
// can signal packer and unpacker with ahb-lite register access
// Summary of operation
// [R01] undefined transmit slot adds no bits
// [R02] unconnected transmit slot is not packed
// [R03] transmit signal starts at byte one..eight
// [R04] transmit signal starts at bit one..eight
// [R05] transmit width one..thirty-two bits, spans bytes
// [R06] continuous transmit: (value minus offset)/resolution
// [R07] software keeps transmit fields from overlapping
// [R08] receive accepts only the configured pgn
// [R09] optional source address filter on receive
// [R10] selected sender address limited to 253
// [R11] receive signal starts at byte one..eight
// [R12] receive signal starts at bit one..eight
// [R13] receive width one..thirty-two bits
// [R14] continuous receive: raw times resolution plus offset
// [R15] receive output resets after autoreset time
// [R16] periodic send at rate; zero means on request
// [R17] sent data length zero..eight bytes
// [R18] bit one is lsb, low byte first
// [R19] oversize encoded values saturate to field maximum
module can_signal_pack_unpack
	import can_pack_pkg::*;
#(
	parameter int unsigned ms_cycles = MS_CYC
)
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output var logic hreadyout,
	output var logic hresp,
	output var logic [31:0] hrdata,
	// internal signal sources
	input wire logic [N_SRC-1:0][31:0] src_val,
	// frame from the can controller
	input wire logic rx_in_valid,
	input wire can_frame_t rx_in,
	// frame to the can controller
	output var logic tx_valid,
	output var can_frame_t tx_frame,
	// received signal
	output var logic rx_valid,
	output var logic rx_live,
	output var logic [31:0] rx_value
);
	state_t st;
	state_t next_st;
	logic [63:0] fmask [N_SLOT];
	logic [63:0] fbits [N_SLOT];
	logic [63:0] packed_data;
	logic [63:0] len_mask;
	logic [63:0] rx_sh;
	logic [31:0] rx_raw;
	logic [31:0] rdata;
	logic [5:0] rx_pos;
	logic signed [63:0] rx_scl;
	logic ms_tick;
	logic rx_hit;
	logic due;

	function automatic logic [31:0] size_mask(input logic [5:0] size);
		size_mask = (size >= MAX_SIZE) ? 32'hffffffff : 32'((33'h1 << size) - 33'h1);
	endfunction

	function automatic logic [3:0] clamp_pos(input logic [3:0] v);
		clamp_pos = (v == 4'h0) ? 4'h1 : (v > MAX_POS) ? MAX_POS : v;
	endfunction

	// position of bit one of byte one is data bit 0
	function automatic logic [5:0] bit_index(input slot_cfg_t c);
		bit_index = {3'(c.byte_pos - 4'h1), 3'h0} + {3'h0, 3'(c.bit_pos - 4'h1)};
	endfunction

	function automatic slot_cfg_t cfg_of(input logic [31:0] w);
		logic [5:0] sz;
		sz = w[F_SIZE+:6];
		cfg_of.kind = (w[F_TYPE+:2] > T_CONT) ? T_UNDEF : w[F_TYPE+:2];
		cfg_of.src = w[F_SRC+:3];
		cfg_of.byte_pos = clamp_pos(w[F_BYTE+:4]);
		cfg_of.bit_pos = clamp_pos(w[F_BIT+:4]);
		cfg_of.size = (sz == 6'h0) ? 6'h01 : (sz > MAX_SIZE) ? MAX_SIZE : sz;
	endfunction

	function automatic logic [31:0] word_of(input slot_cfg_t c);
		word_of = '0;
		word_of[F_TYPE+:2] = c.kind;
		word_of[F_SRC+:3] = c.src;
		word_of[F_BYTE+:4] = c.byte_pos;
		word_of[F_BIT+:4] = c.bit_pos;
		word_of[F_SIZE+:6] = c.size;
	endfunction

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// per-slot encoder
	for (genvar g = 0; g < N_SLOT; g++)
	begin : enc
		logic signed [63:0] diff;
		logic signed [63:0] scl;
		logic [31:0] val;
		logic [31:0] raw;
		logic [31:0] lim;
		logic [5:0] pos;
		logic live;
		always_comb
		begin
			live = st.slot[g].kind != T_UNDEF && st.slot[g].src != 3'h0 && st.slot[g].src <= 3'(N_SRC); // [R01] [R02]
			val = live ? src_val[2'(st.slot[g].src - 3'h1)] : 32'h0; // [R02]
			lim = size_mask(st.slot[g].size); // [R05]
			diff = 64'(signed'(val)) - 64'(signed'(st.slot_off[g]));
			// resolution is held as its 16.16 reciprocal so no divider is needed
			scl = (diff * 64'(signed'(st.slot_res[g]))) >>> FRAC; // [R06]
			if (st.slot[g].kind == T_CONT)
				raw = (scl < 0) ? 32'h0 : (scl > $signed({32'h0, lim})) ? lim : scl[31:0]; // [R19]
			else
				raw = (val > lim) ? lim : val; // [R19]
			pos = bit_index(st.slot[g]); // [R03] [R04] [R18]
			fmask[g] = live ? 64'(lim) << pos : 64'h0; // [R05]
			fbits[g] = 64'(raw) << pos;
		end
		undef_slot_a: assert property (st.slot[g].kind == T_UNDEF |-> fmask[g] == 64'h0) // [R01]
			else $error("undefined slot drives frame bits");
		sat_field_a: assert property (raw <= lim) // [R19]
			else $error("encoded value exceeds field width");
		neg_floor_a: assert property (st.slot[g].kind == T_CONT && scl < 0 |-> raw == 32'h0) // [R19]
			else $error("negative encoded value not floored");
		// an unconnected slot must leave its bits to the other slots
		nc_slot_a: assert property (st.slot[g].src == 3'h0 |-> fmask[g] == 64'h0) // [R02]
			else $error("unconnected slot drives frame bits");
		field_width_a: assert property (live && pos <= 6'h20 |-> (fmask[g] >> pos) == 64'(lim)) // [R05]
			else $error("slot field width differs from its size");
	end

	always_comb
	begin
		packed_data = 64'h0;
		// later slots win where software let fields overlap
		for (int i = 0; i < N_SLOT; i++)
			packed_data = (packed_data & ~fmask[i]) | (fbits[i] & fmask[i]); // [R07]
		len_mask = 64'((65'h1 << {st.tx_len, 3'h0}) - 65'h1); // [R17]
	end

	always_comb
	begin
		rx_pos = bit_index(st.rx_cfg); // [R11] [R12]
		rx_sh = rx_in.data >> rx_pos;
		rx_raw = rx_sh[31:0] & size_mask(st.rx_cfg.size); // [R13]
		rx_scl = (($signed({32'h0, rx_raw}) * 64'(signed'(st.rx_res))) >>> FRAC) + 64'(signed'(st.rx_off)); // [R14]
		rx_hit = rx_in_valid && st.rx_cfg.kind != T_UNDEF && rx_in.pgn == st.rx_pgn // [R08]
			&& (!st.rx_filt || rx_in.src == st.rx_sel); // [R09]
	end

	// read mux, sampled in the address phase
	always_comb
	begin
		rdata = 32'h0;
		unique case (haddr)
			A_TX_CTRL: rdata = {20'h0, st.tx_len, 6'h0, st.tx_req, st.tx_en};
			A_TX_RATE: rdata = 32'(st.tx_rate);
			A_TX_PGN: rdata = 32'(st.tx_pgn);
			A_RX_CFG: rdata = word_of(st.rx_cfg) | {st.rx_sel, 21'h0, st.rx_filt, 2'h0};
			A_RX_PGN: rdata = 32'(st.rx_pgn);
			A_RX_RES: rdata = st.rx_res;
			A_RX_OFF: rdata = st.rx_off;
			A_RX_ARST: rdata = 32'(st.rx_arst);
			A_RX_VAL: rdata = st.rx_value;
			A_STATUS: rdata = {29'h0, st.tx_en, st.tx_req, st.rx_live};
			default: rdata = 32'h0;
		endcase
		for (int i = 0; i < N_SLOT; i++)
		begin
			if (haddr == 8'(A_SLOT0 + 8'(i) * SLOT_STRIDE + S_CFG))
				rdata = word_of(st.slot[i]);
			if (haddr == 8'(A_SLOT0 + 8'(i) * SLOT_STRIDE + S_RES))
				rdata = st.slot_res[i];
			if (haddr == 8'(A_SLOT0 + 8'(i) * SLOT_STRIDE + S_OFF))
				rdata = st.slot_off[i];
		end
	end

	always_comb
	begin
		next_st = st;
		next_st.tx_valid = 1'b0;
		next_st.rx_strobe = 1'b0;
		ms_tick = st.ms_cnt == CNT_W'(ms_cycles - 1);
		next_st.ms_cnt = ms_tick ? '0 : st.ms_cnt + 1'b1;

		// zero-wait slave: data phase always in the next cycle
		next_st.wr_pend = hsel && hready && htrans[1] && hwrite;
		next_st.wr_addr = haddr;
		if (hsel && hready && htrans[1] && !hwrite)
			next_st.hrdata = rdata;

		// transmit scheduling
		due = 1'b0;
		if (!st.tx_en || st.tx_rate == '0)
			next_st.tx_ms = '0;
		else if (ms_tick)
		begin
			due = st.tx_ms + 1'b1 >= st.tx_rate; // [R16]
			next_st.tx_ms = due ? '0 : st.tx_ms + 1'b1;
		end
		if (st.tx_en && (st.tx_req || due)) // [R16]
		begin
			next_st.tx_valid = 1'b1;
			next_st.tx_frame = '{st.tx_pgn, OWN_ADDR, st.tx_len, packed_data & len_mask}; // [R17]
		end
		if (st.tx_en && (st.tx_req || due) || !st.tx_en)
			next_st.tx_req = 1'b0;

		// receive and autoreset; a matching frame beats the timeout
		if (rx_hit)
		begin
			next_st.rx_value = (st.rx_cfg.kind == T_CONT) ? rx_scl[31:0] : rx_raw; // [R14]
			next_st.rx_strobe = 1'b1;
			next_st.rx_live = 1'b1;
			next_st.rx_ms = '0;
		end
		else if (ms_tick && st.rx_live)
		begin
			if (st.rx_arst != '0 && st.rx_ms + 1'b1 >= st.rx_arst) // [R15]
			begin
				next_st.rx_value = 32'h0;
				next_st.rx_live = 1'b0;
				next_st.rx_ms = '0;
			end
			else
				next_st.rx_ms = st.rx_ms + 1'b1;
		end

		// register writes in the data phase; request set wins over the send clear
		if (st.wr_pend)
		begin
			unique case (st.wr_addr)
				A_TX_CTRL:
				begin
					next_st.tx_en = hwdata[F_EN];
					next_st.tx_req = next_st.tx_req | (hwdata[F_REQ] & hwdata[F_EN]); // [R16]
					next_st.tx_len = (hwdata[F_LEN+:4] > MAX_LEN) ? MAX_LEN : hwdata[F_LEN+:4]; // [R17]
				end
				A_TX_RATE: next_st.tx_rate = hwdata[CNT_W-1:0];
				A_TX_PGN: next_st.tx_pgn = hwdata[17:0];
				A_RX_CFG:
				begin
					next_st.rx_cfg = cfg_of(hwdata); // [R11] [R12] [R13]
					next_st.rx_cfg.src = 3'h0;
					next_st.rx_filt = hwdata[F_FILT];
					next_st.rx_sel = (hwdata[F_SEL+:8] > MAX_SEL) ? MAX_SEL : hwdata[F_SEL+:8]; // [R10]
				end
				A_RX_PGN: next_st.rx_pgn = hwdata[17:0];
				A_RX_RES: next_st.rx_res = hwdata;
				A_RX_OFF: next_st.rx_off = hwdata;
				A_RX_ARST: next_st.rx_arst = hwdata[CNT_W-1:0];
				default: ;
			endcase
			for (int i = 0; i < N_SLOT; i++)
			begin
				if (st.wr_addr == 8'(A_SLOT0 + 8'(i) * SLOT_STRIDE + S_CFG))
					next_st.slot[i] = cfg_of(hwdata); // [R03] [R04] [R05]
				if (st.wr_addr == 8'(A_SLOT0 + 8'(i) * SLOT_STRIDE + S_RES))
					next_st.slot_res[i] = hwdata;
				if (st.wr_addr == 8'(A_SLOT0 + 8'(i) * SLOT_STRIDE + S_OFF))
					next_st.slot_off[i] = hwdata;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st <= ST_RST;
		else
			st <= next_st;
	end

	assign hreadyout = st.hready_o;
	assign hresp = st.hresp;
	assign hrdata = st.hrdata;
	assign tx_valid = st.tx_valid;
	assign tx_frame = st.tx_frame;
	assign rx_valid = st.rx_strobe;
	assign rx_live = st.rx_live;
	assign rx_value = st.rx_value;

	// a request landing beside a periodic send legally gives two frames in a row
	tx_pulse_a: assert property (tx_valid |-> $past(st.tx_en) && ($past(st.tx_req) || $past(due))) // [R16]
		else $error("frame sent without request or period");
	tx_len_a: assert property (tx_valid |-> tx_frame.len <= MAX_LEN) // [R17]
		else $error("frame length above eight bytes");
	rx_pgn_a: assert property (rx_valid |-> $past(rx_in_valid) && $past(rx_in.pgn) == $past(st.rx_pgn)) // [R08]
		else $error("frame with foreign pgn accepted");
	rx_src_a: assert property (rx_valid && $past(st.rx_filt) |-> $past(rx_in.src) == $past(st.rx_sel)) // [R09]
		else $error("frame from unselected sender accepted");
	sel_range_a: assert property (st.rx_sel <= MAX_SEL) // [R10]
		else $error("selected sender above 253");
	rx_reset_a: assert property ($fell(rx_live) |-> rx_value == 32'h0 && $past(st.rx_arst) != '0) // [R15]
		else $error("autoreset did not clear output");
	rx_width_a: assert property (rx_valid && $past(st.rx_cfg.kind) == T_DISC |-> // [R13]
		(64'(rx_value) >> $past(st.rx_cfg.size)) == 64'h0)
		else $error("received field wider than its size");
	bus_rd_a: assert property (hsel && hready && htrans[1] && !hwrite && haddr == A_STATUS |=> // [R15]
		hrdata[0] == $past(st.rx_live) && hreadyout)
		else $error("status read does not show receive state");

	// transmit side
	tx_off_a: assert property (!st.tx_en |=> !tx_valid) // [R16]
		else $error("frame sent while transmit disabled");
	on_request_a: assert property (tx_valid && $past(st.tx_rate) == '0 |-> $past(st.tx_req)) // [R16]
		else $error("frame sent with zero rate and no request");
	tx_hold_a: assert property (!tx_valid |-> $stable(tx_frame)) // [R16]
		else $error("sent frame changed without a send");
	len_pad_a: assert property (tx_valid |-> (tx_frame.data >> {tx_frame.len, 3'h0}) == 64'h0) // [R17]
		else $error("data bytes beyond length are not zero");

	// receive side
	rx_idle_a: assert property (!rx_in_valid |=> !rx_valid) // [R08]
		else $error("receive strobe without a frame");
	rx_reject_a: assert property (rx_in_valid && rx_in.pgn != st.rx_pgn |=> !rx_valid) // [R08]
		else $error("foreign pgn frame taken");
	rx_filt_a: assert property (rx_in_valid && st.rx_filt && rx_in.src != st.rx_sel |=> !rx_valid) // [R09]
		else $error("unselected sender frame taken");
	rx_strobe_a: assert property (rx_valid |-> rx_live) // [R15]
		else $error("matching frame did not set receive live");
	rx_keep_a: assert property (!rx_hit && !ms_tick |=> $stable(rx_value) && $stable(rx_live)) // [R15]
		else $error("receive output changed without frame or tick");
	arst_off_a: assert property (st.rx_arst == '0 && rx_live |=> rx_live) // [R15]
		else $error("autoreset fired while disabled");
	rx_dead_a: assert property (!rx_live |-> rx_value == 32'h0) // [R15]
		else $error("receive value kept without live frame");

	// zero-wait okay slave
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or answered an error");
endmodule

// file: tb/can_ecu_model.sv
// behavioural far-side ecu that puts frames on the receive port
module can_ecu_model
	import can_pack_pkg::*;
(
	// clock
	input wire logic hclk,
	// to the block
	output var logic rx_in_valid,
	output var can_frame_t rx_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		rx_in_valid = 1'b0;
		rx_in = '0;
	end
	// an idle port shows the inverse, so a stale frame never looks valid
	task automatic send(input can_frame_t f);
		@(posedge hclk);
		rx_in_valid <= 1'b1;
		rx_in <= f;
		@(posedge hclk);
		rx_in_valid <= 1'b0;
		rx_in <= ~f;
	endtask
endmodule

// file: tb/tb_can_signal_pack_unpack.sv
// self-checking bench for the can signal packer and unpacker
module tb_can_signal_pack_unpack
	import can_pack_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [7:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic [31:0] hwdata = '0, hrdata, rd, rx_value;
	logic hreadyout, hresp, rx_in_valid, tx_valid, rx_valid, rx_live;
	logic [N_SRC-1:0][31:0] src_val = '0;
	can_frame_t rx_in, tx_frame;
	int error_cnt = 0, checked = 0, cyc = 0, rxn = 0, txn = 0;
	logic [7:0] ra [4] = '{A_TX_CTRL, A_RX_ARST, A_SLOT0, 8'h7c};
	logic [31:0] re [4] = '{32'h800, 32'h1f4, 32'h101112, 32'h0};

	can_signal_pack_unpack #(.ms_cycles(4)) u_can_signal_pack_unpack (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .src_val(src_val), .rx_in_valid(rx_in_valid),
		.rx_in(rx_in), .tx_valid(tx_valid), .tx_frame(tx_frame),
		.rx_valid(rx_valid), .rx_live(rx_live), .rx_value(rx_value));
	can_ecu_model u_can_ecu_model (.hclk(hclk), .rx_in_valid(rx_in_valid), .rx_in(rx_in));

	always #50 hclk = ~hclk;

	task automatic end_sim();
		if (error_cnt == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] s, e);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask

	// waits for one sent frame and compares its data field
	task automatic wt(input logic [63:0] e);
		for (int k = 0; k < 40 && tx_valid !== 1'b1; k++)
			@(negedge hclk);
		chk("tx_seen", tx_valid, 1);
		chk("tx_data", tx_frame.data, e);
		@(posedge hclk);
	endtask

	function automatic logic [31:0] cfg(input int k, s, by, bi, sz);
		return 32'(k | s << F_SRC | by << F_BYTE | bi << F_BIT | sz << F_SIZE);
	endfunction

	function automatic logic [63:0] pack(input logic [31:0] v, input int by, bi, sz);
		logic [63:0] m;
		m = (64'h1 << sz) - 64'h1;
		if (v > m)
			v = m[31:0];
		return (v & m) << ((by - 1) * 8 + bi - 1);
	endfunction

	always @(negedge hclk)
	begin
		rxn += (rx_valid === 1'b1);
		txn += (tx_valid === 1'b1);
	end

	// generous ceiling: the whole sequence needs about three hundred cycles
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_sim();
		end
	end

	initial
	begin
		can_frame_t f;
		logic [31:0] v;
		int by, bi, sz, n;
		void'($urandom(32'h2baf));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 4; i++)
		begin
			bus(0, ra[i], 0);
			chk("reset_reg", rd, re[i]);
		end
		for (int i = 0; i < 2; i++)
		begin
			src_val[0] <= i ? 32'hc8 : 32'ha;
			src_val[1] <= i ? 32'h0 : 32'hffffff9c;
			bus(1, A_TX_CTRL, 32'h803);
			wt(i ? 64'h7d00ffff : 64'h9088);
		end
		chk("tx_pgn", tx_frame.pgn, 18'h0f013);
		chk("tx_src", tx_frame.src, OWN_ADDR);
		// slots one and two are made inactive in byte eight, clear of slot zero
		bus(1, A_SLOT0 + 8'h10, cfg(T_CONT, 0, 8, 1, 4));
		bus(1, A_SLOT0 + 8'h20, cfg(T_UNDEF, 3, 8, 5, 4));
		for (int i = 0; i < 8; i++)
		begin
			by = $urandom_range(1, 4);
			bi = (i == 0) ? 8 : $urandom_range(1, 8);
			sz = (i == 0) ? 24 : $urandom_range(1, 24);
			v = i[0] ? $urandom : $urandom_range(0, 255);
			src_val <= {$urandom, $urandom, $urandom, v};
			bus(1, A_SLOT0, cfg(T_DISC, 1, by, bi, sz));
			bus(1, A_TX_CTRL, 32'h803);
			wt(pack(v, by, bi, sz));
		end
		src_val[0] <= 32'h12345678;
		bus(1, A_SLOT0, cfg(T_DISC, 1, 1, 1, 32));
		bus(1, A_TX_CTRL, 32'h203);
		wt(64'h5678);
		chk("tx_len", tx_frame.len, 2);
		bus(1, A_TX_CTRL, 32'h2);
		bus(1, A_TX_RATE, 0);
		n = txn;
		bus(1, A_TX_CTRL, 32'h801);
		repeat (40) @(posedge hclk);
		chk("tx_idle", txn - n, 0);
		bus(1, A_TX_CTRL, 0);
		bus(1, A_TX_RATE, 2);
		bus(1, A_TX_CTRL, 32'h801);
		n = txn;
		repeat (80) @(posedge hclk);
		n = txn - n;
		chk("tx_period", n inside {[9:11]}, 1);
		bus(1, A_TX_CTRL, 0);
		bus(1, A_RX_CFG, 32'h33000004 | cfg(T_DISC, 0, 3, 5, 12));
		bus(1, A_RX_PGN, 32'h1fe00);
		bus(1, A_RX_ARST, 0);
		for (int i = 0; i < 3; i++)
		begin
			f = '{i ? 18'h1fe00 : 18'h1fe01, i == 1 ? 8'h34 : 8'h33, 4'h8, {$urandom, $urandom}};
			n = rxn;
			u_can_ecu_model.send(f);
			repeat (2) @(negedge hclk);
			chk("rx_count", rxn - n, i == 2);
		end
		chk("rx_disc", rx_value, (f.data >> 20) & 64'hfff);
		repeat (40) @(posedge hclk);
		chk("rx_hold", rx_live, 1);
		bus(0, A_STATUS, 0);
		chk("status", rd, 32'h1);
		chk("hresp", {hresp, hreadyout}, 1);
		bus(1, A_RX_CFG, 32'hff000004 | cfg(T_CONT, 0, 1, 1, 8));
		bus(0, A_RX_CFG, 0);
		chk("rx_sel", rd[31:24], 8'hfd);
		bus(1, A_RX_CFG, cfg(T_CONT, 0, 1, 1, 8));
		bus(1, A_RX_RES, 32'h20000);
		bus(1, A_RX_OFF, 32'hfffffff6);
		bus(1, A_RX_ARST, 2);
		f = '{18'h1fe00, 8'h5a, 4'h8, 64'h40};
		u_can_ecu_model.send(f);
		@(negedge hclk);
		chk("rx_cont", rx_value, 118);
		chk("rx_live", rx_live, 1);
		repeat (16) @(posedge hclk);
		chk("rx_reset", {rx_live, rx_value}, 0);
		end_sim();
	end
endmodule
